// File: rtl/escf_top.sv
`timescale 1ns/100ps
module escf_top #(
    parameter logic [2:0] CHIP_REV = 3'h5 // Arbitrary value
) (
    input wire logic CLOCK_I,
    input wire logic RSTN_I,
    input wire logic SCK_I,
    input wire logic SS_N_I,
    input wire logic MOSI_I,
    output logic MISO_O,
    input wire logic [11:0] ANGLE_I,
    input wire logic [5:0] AGC_LEVEL_I,
    input wire logic CONV_OVF_I,
    input wire logic MATH_OVF_I,
    input wire logic RANGE_ERR_I,
    input wire logic BIAS_FAULT_I,
    input wire logic CONV_DONE_I,
    input wire logic SLEEPING_I,
    input wire logic OSC_READY_I,
    input wire logic TRIM_DONE_I,
    input wire escf_pkg::escf_cfg_t TRIM_CFG_I,
    output logic CONV_START_O,
    output logic OSC_START_O,
    output logic TRIM_LOAD_O,
    output logic LOGIC_RST_O,
    output escf_pkg::escf_cfg_t CFG_O,
    output logic POR_CELL_OFF_O,
    output logic [13:0] FAULT_STATUS_O
);
    import escf_pkg::*;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [15:0] make_rsp(input logic [13:0] data, input logic flag);
        escf_rsp_t rsp;
        rsp.data = data;
        rsp.transmission_fault_flag = flag;
        rsp.even_check_bit = ^{data, flag};
        return rsp;
    endfunction : make_rsp

    function automatic logic is_writable(input logic [13:0] addr);
        return (addr == ADDR_AGC) || (addr == ADDR_SYS_CFG) || (addr == ADDR_POR_OFF)
            || (addr == ADDR_SOFT_RESET) || (addr == ADDR_MASTER_RESET);
    endfunction : is_writable

    // ****************************************
    // Declarations
    // ****************************************
    logic [15:0] rx_word;
    logic [4:0] rx_count;
    logic rx_empty;
    logic [2:0] empty_sync;
    logic [15:0] tx_word;
    logic ss_meta;
    logic ss_sync;
    logic ss_last;
    logic frame_end;
    escf_cmd_t rx_cmd;
    logic clk_bad;
    logic par_bad;
    logic frame_bad;
    logic addr_bad;
    logic do_clear;
    logic do_trigger;
    logic go_pending;
    logic wr_agc;
    logic wr_cfg;
    logic wr_por;
    logic wr_soft;
    logic wr_master;
    logic [13:0] rd_data;
    logic set_ef;
    logic next_ef;
    logic spi_rst;
    logic seq_start;
    logic load_done;
    logic conv_trig;
    logic pending;
    logic [13:0] pend_addr;
    logic transmission_fault_flag;
    logic [2:0] spi_fault;
    logic [2:0] spi_fault_set;
    logic [2:0] conv_fault;
    logic [2:0] conv_fault_in;
    logic measure_window_flag;
    logic activity_flag;
    logic weak_field_alarm;
    logic strong_field_alarm;
    logic [13:0] fault_word;
    logic [13:0] sys_word;
    logic [7:0] por_off;
    escf_cfg_t cfg;
    escf_seq_t seq;
    escf_seq_t next_seq;

    // ****************************************
    // Link side
    // ****************************************
    escf_link u_link (
        .sck_i(SCK_I),
        .rst_n_i(RSTN_I),
        .ss_n_i(SS_N_I),
        .mosi_i(MOSI_I),
        .tx_word_i(tx_word),
        .rx_word_o(rx_word),
        .rx_count_o(rx_count),
        .rx_empty_o(rx_empty),
        .miso_o(MISO_O)
    );

    // Select edge marks the end of a frame; word and count are frozen then
    // Empty marker runs in step with select; its pre-rise value flags clockless frames
    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ss_meta <= 1'b1;
            ss_sync <= 1'b1;
            ss_last <= 1'b1;
            empty_sync <= 3'h7;
        end else begin
            ss_meta <= SS_N_I;
            ss_sync <= ss_meta;
            ss_last <= ss_sync;
            empty_sync <= {empty_sync[1:0], rx_empty};
        end
    end

    assign frame_end = ss_sync & ~ss_last;

    // ****************************************
    // Frame decode
    // ****************************************
    always_comb begin
        rx_cmd = escf_cmd_t'(rx_word);
        clk_bad = empty_sync[2] | (rx_count != FRAME_COUNT_FULL);
        par_bad = ^rx_word;
        frame_bad = clk_bad | par_bad;
        addr_bad = 1'b0;
        do_clear = 1'b0;
        do_trigger = 1'b0;
        go_pending = 1'b0;
        wr_agc = 1'b0;
        wr_cfg = 1'b0;
        wr_por = 1'b0;
        wr_soft = 1'b0;
        wr_master = 1'b0;
        rd_data = 14'h0000;
        if (frame_end && !frame_bad) begin
            if (pending) begin
                wr_agc = (pend_addr == ADDR_AGC);
                wr_cfg = (pend_addr == ADDR_SYS_CFG);
                wr_por = (pend_addr == ADDR_POR_OFF);
                wr_soft = (pend_addr == ADDR_SOFT_RESET);
                wr_master = (pend_addr == ADDR_MASTER_RESET);
                rd_data = rx_word[FRAME_BITS-1:DATA_LSB];
            end else if (rx_cmd.read_write_selector) begin
                case (rx_cmd.addr)
                    ADDR_ANGLE: begin
                        rd_data = {weak_field_alarm, strong_field_alarm, ANGLE_I};
                        do_trigger = 1'b1;
                    end
                    ADDR_AGC: rd_data = {8'h00, cfg.agc};
                    ADDR_SYS_CFG: rd_data = sys_word;
                    ADDR_POR_OFF: rd_data = {6'h00, por_off};
                    ADDR_FAULT_STATUS: rd_data = fault_word;
                    ADDR_CLEAR_FAULT: do_clear = 1'b1;
                    default: addr_bad = 1'b1;
                endcase
            end else if (rx_cmd.addr == ADDR_NOP) begin
                rd_data = 14'h0000;
            end else if (is_writable(rx_cmd.addr)) begin
                go_pending = 1'b1;
            end else begin
                addr_bad = 1'b1;
            end
        end
    end

    assign set_ef = frame_end & (frame_bad | addr_bad);
    assign next_ef = (transmission_fault_flag & ~do_clear) | set_ef;
    assign spi_rst = wr_master | (wr_soft & rx_word[SERIAL_REGS_RESET_BIT_POS]);
    assign seq_start = wr_soft | wr_master;
    assign load_done = (seq == SEQ_LOAD) & TRIM_DONE_I;
    assign conv_trig = do_trigger | load_done;

    // ****************************************
    // Serial interface registers
    // ****************************************
    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            pending <= 1'b0;
            pend_addr <= ADDR_NOP;
        end else if (spi_rst) begin
            pending <= 1'b0;
            pend_addr <= ADDR_NOP;
        end else if (frame_end) begin
            pending <= go_pending;
            if (go_pending) begin
                pend_addr <= rx_cmd.addr;
            end
        end
    end

    // Set wins over a clear in the same frame
    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            transmission_fault_flag <= 1'b0;
        end else if (spi_rst) begin
            transmission_fault_flag <= 1'b0;
        end else begin
            transmission_fault_flag <= next_ef;
        end
    end

    // Answer is built at frame end and shifted out in the next frame
    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            tx_word <= 16'h0000;
        end else if (spi_rst) begin
            tx_word <= 16'h0000;
        end else if (frame_end) begin
            if (do_clear) begin
                tx_word <= 16'h0000;
            end else begin
                tx_word <= make_rsp(rd_data, next_ef);
            end
        end
    end

    assign spi_fault_set = {frame_end & addr_bad, frame_end & clk_bad, frame_end & par_bad};

    generate
        for (genvar i = 0; i < 3; i++) begin : g_spi_fault
            always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
                if (!RSTN_I) begin
                    spi_fault[i] <= 1'b0;
                end else if (spi_rst) begin
                    spi_fault[i] <= 1'b0;
                end else begin
                    spi_fault[i] <= (spi_fault[i] & ~do_clear) | spi_fault_set[i];
                end
            end
        end
    endgenerate

    // ****************************************
    // Configuration registers
    // ****************************************
    // Trim reload beats a host write landing in the same cycle
    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            cfg <= CFG_RESET;
        end else if (load_done) begin
            cfg <= TRIM_CFG_I;
        end else if (wr_agc) begin
            cfg.agc <= rd_data[5:0];
        end else if (wr_cfg) begin
            cfg.invert_spinning <= rd_data[SC_INVERT];
            cfg.fe_bw <= rd_data[SC_BW_LSB +: 2];
            cfg.fe_gain <= rd_data[SC_GAIN_LSB +: 2];
            cfg.break_agc_loop <= rd_data[SC_BREAK];
        end
    end

    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            por_off <= POR_OFF_RESET;
        end else if (wr_por) begin
            por_off <= rd_data[7:0];
        end
    end

    always_comb begin
        sys_word = 14'h0000;
        sys_word[13:12] = RESOLUTION_12;
        sys_word[11:9] = CHIP_REV;
        sys_word[SC_INVERT] = cfg.invert_spinning;
        sys_word[SC_BW_LSB +: 2] = cfg.fe_bw;
        sys_word[SC_GAIN_LSB +: 2] = cfg.fe_gain;
        sys_word[SC_BREAK] = cfg.break_agc_loop;
    end

    // ****************************************
    // Reset sequence
    // ****************************************
    // Power-on starts in the load state, so trim is always reloaded
    always_comb begin
        next_seq = seq;
        unique case (seq)
            SEQ_IDLE: begin
                if (seq_start) begin
                    next_seq = SLEEPING_I ? SEQ_WAKE : SEQ_LOAD;
                end
            end
            SEQ_WAKE: begin
                if (OSC_READY_I) begin
                    next_seq = SEQ_LOAD;
                end
            end
            SEQ_LOAD: begin
                if (TRIM_DONE_I) begin
                    next_seq = SEQ_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            seq <= SEQ_LOAD;
            OSC_START_O <= 1'b0;
            TRIM_LOAD_O <= 1'b1;
            LOGIC_RST_O <= 1'b0;
        end else begin
            seq <= next_seq;
            OSC_START_O <= (next_seq == SEQ_WAKE);
            TRIM_LOAD_O <= (next_seq == SEQ_LOAD);
            LOGIC_RST_O <= seq_start;
        end
    end

    // ****************************************
    // Conversion tracking
    // ****************************************
    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            CONV_START_O <= 1'b0;
        end else begin
            CONV_START_O <= conv_trig;
        end
    end

    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            measure_window_flag <= 1'b0;
        end else if (do_trigger) begin
            measure_window_flag <= 1'b1;
        end else if (CONV_DONE_I || seq_start) begin
            measure_window_flag <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            activity_flag <= 1'b0;
        end else if (conv_trig) begin
            activity_flag <= 1'b1;
        end else if (CONV_DONE_I || SLEEPING_I || seq_start) begin
            activity_flag <= 1'b0;
        end
    end

    // Faults only count while a computation runs; a new conversion clears
    assign conv_fault_in = {RANGE_ERR_I, MATH_OVF_I, CONV_OVF_I};

    generate
        for (genvar i = 0; i < 3; i++) begin : g_conv_fault
            always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
                if (!RSTN_I) begin
                    conv_fault[i] <= 1'b0;
                end else begin
                    conv_fault[i] <= (conv_fault[i] & ~conv_trig & ~seq_start)
                        | (conv_fault_in[i] & activity_flag);
                end
            end
        end
    endgenerate

    // ****************************************
    // Alarms and fault status
    // ****************************************
    always_comb begin
        if (conv_fault[0] || conv_fault[1] || BIAS_FAULT_I) begin
            weak_field_alarm = 1'b1;
            strong_field_alarm = 1'b1;
        end else if (AGC_LEVEL_I >= AGC_LEVEL_MAX) begin
            weak_field_alarm = 1'b1;
            strong_field_alarm = 1'b0;
        end else if (AGC_LEVEL_I <= AGC_LEVEL_MIN) begin
            weak_field_alarm = 1'b0;
            strong_field_alarm = 1'b1;
        end else begin
            weak_field_alarm = 1'b0;
            strong_field_alarm = 1'b0;
        end
    end

    always_comb begin
        fault_word = 14'h0000;
        fault_word[FS_PARITY] = spi_fault[0];
        fault_word[FS_CLOCK] = spi_fault[1];
        fault_word[FS_ADDRESS] = spi_fault[2];
        fault_word[FS_WINDOW] = measure_window_flag;
        fault_word[FS_ACTIVITY] = activity_flag;
        fault_word[FS_CONV_OVF] = conv_fault[0];
        fault_word[FS_MATH_OVF] = conv_fault[1];
        fault_word[FS_RANGE] = conv_fault[2];
        fault_word[FS_LOW_ALARM] = strong_field_alarm;
        fault_word[FS_HIGH_ALARM] = weak_field_alarm;
    end

    // ****************************************
    // Registered outputs
    // ****************************************
    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            CFG_O <= CFG_RESET;
            POR_CELL_OFF_O <= 1'b0;
            FAULT_STATUS_O <= 14'h0000;
        end else begin
            CFG_O <= cfg;
            POR_CELL_OFF_O <= (por_off == POR_OFF_KEY);
            FAULT_STATUS_O <= fault_word;
        end
    end

endmodule : escf_top

// File: shared/escf_pkg.sv
package escf_pkg;

    // ****************************************
    // Frame layout
    // ****************************************
    localparam int FRAME_BITS = 16;
    localparam logic [4:0] FRAME_COUNT_FULL = 5'h10;
    localparam logic [4:0] FRAME_COUNT_MAX = 5'h11;
    localparam int DATA_LSB = 2;
    localparam int SERIAL_REGS_RESET_BIT_POS = 2;

    typedef struct packed {
        logic read_write_selector;
        logic [13:0] addr;
        logic even_check_bit;
    } escf_cmd_t;

    typedef struct packed {
        logic [13:0] data;
        logic transmission_fault_flag;
        logic even_check_bit;
    } escf_rsp_t;

    // ****************************************
    // Register addresses
    // ****************************************
    localparam logic [13:0] ADDR_NOP = 14'h0000;
    localparam logic [13:0] ADDR_POR_OFF = 14'h3F22;
    localparam logic [13:0] ADDR_SOFT_RESET = 14'h3C00;
    localparam logic [13:0] ADDR_MASTER_RESET = 14'h33A5;
    localparam logic [13:0] ADDR_CLEAR_FAULT = 14'h3380;
    localparam logic [13:0] ADDR_AGC = 14'h3FF8;
    localparam logic [13:0] ADDR_ANGLE = 14'h3FFF;
    localparam logic [13:0] ADDR_SYS_CFG = 14'h3F20;
    localparam logic [13:0] ADDR_FAULT_STATUS = 14'h33A5;

    // ****************************************
    // Configuration held in the trim store
    // ****************************************
    typedef struct packed {
        logic invert_spinning;
        logic [1:0] fe_bw;
        logic [1:0] fe_gain;
        logic break_agc_loop;
        logic [5:0] agc;
    } escf_cfg_t;

    localparam escf_cfg_t CFG_RESET = '{1'b0, 2'h0, 2'h0, 1'b0, 6'h20};
    localparam logic [7:0] POR_OFF_RESET = 8'h00;
    localparam logic [7:0] POR_OFF_KEY = 8'h5A;
    localparam logic [1:0] RESOLUTION_12 = 2'h0;

    // System configuration word positions
    localparam int SC_INVERT = 8;
    localparam int SC_BW_LSB = 5;
    localparam int SC_GAIN_LSB = 3;
    localparam int SC_BREAK = 2;

    // ****************************************
    // Fault status word positions
    // ****************************************
    localparam int FS_PARITY = 0;
    localparam int FS_CLOCK = 1;
    localparam int FS_ADDRESS = 2;
    localparam int FS_WINDOW = 4;
    localparam int FS_ACTIVITY = 5;
    localparam int FS_CONV_OVF = 8;
    localparam int FS_MATH_OVF = 9;
    localparam int FS_RANGE = 10;
    localparam int FS_LOW_ALARM = 11;
    localparam int FS_HIGH_ALARM = 12;

    // Gain level limits for the alarm bits
    localparam logic [5:0] AGC_LEVEL_MIN = 6'h00;
    localparam logic [5:0] AGC_LEVEL_MAX = 6'h3F;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_WAKE,
        SEQ_LOAD
    } escf_seq_t;

endpackage : escf_pkg

// File: rtl/escf_link.sv
`timescale 1ns/100ps
module escf_link
    import escf_pkg::*;
(
    input wire logic sck_i,
    input wire logic rst_n_i,
    input wire logic ss_n_i,
    input wire logic mosi_i,
    input wire logic [15:0] tx_word_i,
    output logic [15:0] rx_word_o,
    output logic [4:0] rx_count_o,
    output logic rx_empty_o,
    output logic miso_o
);
    import escf_pkg::*;

    // ****************************************
    // Frame start marker
    // ****************************************
    // Held set while select is high; the link clock is dead there
    always_ff @(negedge sck_i or posedge ss_n_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_empty_o <= 1'b1;
        end else if (ss_n_i) begin
            rx_empty_o <= 1'b1;
        end else begin
            rx_empty_o <= 1'b0;
        end
    end

    // ****************************************
    // Receive on falling edge
    // ****************************************
    // Word and count stay frozen after the frame for the core to read
    always_ff @(negedge sck_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_word_o <= 16'h0000;
            rx_count_o <= 5'h00;
        end else if (rx_empty_o) begin
            rx_word_o <= {15'h0000, mosi_i};
            rx_count_o <= 5'h01;
        end else begin
            rx_word_o <= {rx_word_o[14:0], mosi_i};
            if (rx_count_o != FRAME_COUNT_MAX) begin
                rx_count_o <= rx_count_o + 5'h01;
            end
        end
    end

    // ****************************************
    // Transmit on rising edge
    // ****************************************
    always_ff @(posedge sck_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            miso_o <= 1'b0;
        end else if (rx_empty_o) begin
            miso_o <= tx_word_i[FRAME_BITS-1];
        end else if (rx_count_o < FRAME_COUNT_FULL) begin
            miso_o <= tx_word_i[4'(FRAME_COUNT_FULL - 5'h01 - rx_count_o)];
        end else begin
            miso_o <= 1'b0;
        end
    end

endmodule : escf_link

// File: verif/escf_top_chk.sv
`timescale 1ns/100ps
module escf_top_chk (
    input wire logic CLOCK_I,
    input wire logic RSTN_I,
    input wire logic CONV_OVF_I,
    input wire logic CONV_DONE_I,
    input wire logic SLEEPING_I,
    input wire logic TRIM_DONE_I,
    input wire escf_pkg::escf_cfg_t TRIM_CFG_I,
    input wire logic CONV_START_O,
    input wire logic TRIM_LOAD_O,
    input wire logic LOGIC_RST_O,
    input wire escf_pkg::escf_cfg_t CFG_O,
    input wire logic [13:0] FAULT_STATUS_O
);
    import escf_pkg::*;
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RSTN_I);
    a_start_pulse: assert property (CONV_START_O |=> !CONV_START_O)
        else $error("conversion start longer than one cycle");
    a_busy_on_start: assert property ($rose(CONV_START_O) |-> ##[0:2] FAULT_STATUS_O[5])
        else $error("activity flag not set by conversion start");
    a_window_clear: assert property (CONV_DONE_I |-> ##[1:2] !FAULT_STATUS_O[4])
        else $error("window flag not cleared at end of measurement");
    a_sleep_idle: assert property (SLEEPING_I [*3] |-> !FAULT_STATUS_O[5])
        else $error("activity flag high while asleep");
    a_reserved_zero: assert property ({FAULT_STATUS_O[13], FAULT_STATUS_O[7:6]} == 0
        && !FAULT_STATUS_O[3]) else $error("reserved status bit set");
    a_fault_holds: assert property ($fell(|FAULT_STATUS_O[10:8]) |->
        $past(CONV_START_O) || $past(CONV_START_O, 2) || $past(LOGIC_RST_O) || $past(LOGIC_RST_O, 2))
        else $error("latched fault dropped without a new conversion");
    a_ovf_latch: assert property ((CONV_OVF_I && FAULT_STATUS_O[5]) [*3] |->
        ##[0:2] FAULT_STATUS_O[8]) else $error("overflow not latched while measuring");
    a_trim_hold: assert property (TRIM_LOAD_O && !TRIM_DONE_I && !$past(TRIM_DONE_I)
        |=> TRIM_LOAD_O) else $error("trim load dropped before trim data");
    a_cfg_reload: assert property ($fell(TRIM_LOAD_O) |-> ##[0:2] CFG_O == TRIM_CFG_I)
        else $error("configuration not taken from trim store");
    a_reset_pulse: assert property (LOGIC_RST_O |=> !LOGIC_RST_O)
        else $error("logic reset longer than one cycle");
endmodule : escf_top_chk

bind escf_top escf_top_chk chk_u (
    .CLOCK_I(CLOCK_I), .RSTN_I(RSTN_I), .CONV_OVF_I(CONV_OVF_I), .CONV_DONE_I(CONV_DONE_I),
    .SLEEPING_I(SLEEPING_I), .TRIM_DONE_I(TRIM_DONE_I), .TRIM_CFG_I(TRIM_CFG_I),
    .CONV_START_O(CONV_START_O), .TRIM_LOAD_O(TRIM_LOAD_O), .LOGIC_RST_O(LOGIC_RST_O),
    .CFG_O(CFG_O), .FAULT_STATUS_O(FAULT_STATUS_O)
);

// File: verif/escf_host.sv
`timescale 1ns/100ps
module escf_host (
    output logic sck_o,
    output logic ss_n_o,
    output logic mosi_o,
    input wire logic miso_i
);
    initial begin
        sck_o = 1'b0; // Clock stands still between frames
        ss_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    // Any count other than 16 is a deliberately broken frame
    task automatic frame(input logic [14:0] hi, input logic bad, input int n,
        output logic [15:0] rsp);
        logic [31:0] w;
        w = {hi, ^hi ^ bad, 16'h0000};
        rsp = 16'h0000;
        ss_n_o = 1'b0;
        for (int i = 0; i < n; i++) begin
            #12 mosi_o = w[31 - i];
            #20 sck_o = 1'b1;
            #32 rsp = {rsp[14:0], miso_i};
            sck_o = 1'b0;
        end
        #32 ss_n_o = 1'b1;
        mosi_o = ~mosi_o; // Released line shows no stale value
        #400;
    endtask : frame
endmodule : escf_host

// File: verif/tb_escf_top.sv
`timescale 1ns/100ps
module tb_escf_top;
    import escf_pkg::*;
    localparam escf_cfg_t TRIM = '{1'b1, 2'h2, 2'h1, 1'b0, 6'h15};
    localparam logic [5:0] LV [4] = '{6'h10, 6'h00, 6'h3F, 6'h10};
    localparam logic [1:0] AL [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
    localparam int CN [4] = '{16, 15, 17, 16};
    localparam int EI [4] = '{FS_PARITY, FS_CLOCK, FS_CLOCK, FS_ADDRESS};
    logic clk = 1'b0;
    logic rst_n, sck, ss_n, mosi, miso, conv_ovf, math_ovf, range_err, bias, done;
    logic sleeping, osc_rdy, trim_done, tl_d, conv_start, osc_start, trim_load, logic_rst;
    logic saw_rst, saw_osc, saw_start, por_cell_off;
    logic [11:0] angle;
    logic [5:0] agc_lvl;
    escf_cfg_t cfg;
    logic [13:0] fstat;
    logic [15:0] rsp;
    int fail_count = 0;
    int num_checks = 0;

    always #5 clk = ~clk;

    escf_top dut_u (
        .CLOCK_I(clk), .RSTN_I(rst_n), .SCK_I(sck), .SS_N_I(ss_n), .MOSI_I(mosi),
        .MISO_O(miso), .ANGLE_I(angle), .AGC_LEVEL_I(agc_lvl), .CONV_OVF_I(conv_ovf),
        .MATH_OVF_I(math_ovf), .RANGE_ERR_I(range_err), .BIAS_FAULT_I(bias),
        .CONV_DONE_I(done), .SLEEPING_I(sleeping), .OSC_READY_I(osc_rdy),
        .TRIM_DONE_I(trim_done), .TRIM_CFG_I(TRIM), .CONV_START_O(conv_start),
        .OSC_START_O(osc_start), .TRIM_LOAD_O(trim_load), .LOGIC_RST_O(logic_rst),
        .CFG_O(cfg), .POR_CELL_OFF_O(por_cell_off), .FAULT_STATUS_O(fstat)
    );
    escf_host host_u (.sck_o(sck), .ss_n_o(ss_n), .mosi_o(mosi), .miso_i(miso));

    // Trim answers a cycle late so the wait state is really seen
    always @(negedge clk) begin
        tl_d <= trim_load;
        trim_done <= trim_load & tl_d;
        osc_rdy <= osc_start;
        if (osc_start)
            sleeping <= 1'b0;
        saw_rst <= saw_rst | logic_rst;
        saw_osc <= saw_osc | osc_start;
        saw_start <= saw_start | conv_start;
    end

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wt(ref logic s);
        for (int i = 0; i < 400 && s !== 1'b1; i++)
            @(posedge clk);
        if (s !== 1'b1) begin
            fail_count++;
            $display("MISMATCH t=%0t got=0 exp=1", $time);
            conclude();
        end
    endtask : wt

    function automatic logic [15:0] ans(input logic [13:0] d, input logic f);
        return {d, f, ^{d, f}};
    endfunction : ans

    task automatic xf(input logic [14:0] hi, input logic bad = 1'b0, input int n = 16);
        host_u.frame(hi, bad, n, rsp);
    endtask : xf

    task automatic wr(input logic [13:0] a, input logic [13:0] d);
        xf({1'b0, a});
        xf({d, 1'b0});
    endtask : wr

    task automatic rd(input logic [13:0] a, input logic [15:0] exp);
        xf({1'b1, a});
        xf(15'h0000);
        chk(rsp, exp);
    endtask : rd

    task automatic fin();
        @(negedge clk) done = 1'b1;
        @(negedge clk) done = 1'b0;
        repeat (3) @(negedge clk);
    endtask : fin

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        {rst_n, conv_ovf, math_ovf, range_err, bias, done, sleeping} = 7'h00;
        {osc_rdy, trim_done, tl_d, saw_rst, saw_osc, saw_start} = 6'h00;
        angle = 12'h000;
        agc_lvl = 6'h10;
        repeat (16) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        repeat (30) @(negedge clk);
        chk({4'h0, cfg}, {4'h0, TRIM});
        fin();
        xf(15'h0000);
        xf(15'h0000);
        chk(rsp, 16'h0000);
        wr(ADDR_AGC, 14'h002A);
        xf(15'h0000);
        chk(rsp, ans(14'h002A, 1'b0));
        chk({10'h000, cfg.agc}, 16'h002A);
        rd(ADDR_AGC, ans(14'h002A, 1'b0));
        wr(ADDR_POR_OFF, {6'h00, POR_OFF_KEY});
        rd(ADDR_POR_OFF, ans({6'h00, POR_OFF_KEY}, 1'b0));
        chk({15'h0000, por_cell_off}, 16'h0001);
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            agc_lvl = LV[i];
            angle = {LV[i], LV[i]};
            bias = (i == 3);
            rd(ADDR_ANGLE, ans({AL[i], LV[i], LV[i]}, 1'b0));
            fin();
        end
        bias = 1'b0;
        {conv_ovf, math_ovf, range_err} = 3'h7;
        repeat (4) @(negedge clk);
        chk({5'h00, fstat[10:0]}, 16'h0000);
        xf({1'b1, ADDR_ANGLE});
        chk({5'h00, fstat[10:0]}, 16'h0730);
        @(negedge clk) {conv_ovf, math_ovf, range_err} = 3'h0;
        fin();
        chk({5'h00, fstat[10:0]}, 16'h0700);
        rd(ADDR_FAULT_STATUS, ans(14'h1F00, 1'b0));
        xf({1'b1, ADDR_ANGLE});
        chk({5'h00, fstat[10:0]}, 16'h0030);
        fin();
        chk({5'h00, fstat[10:0]}, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            xf(k == 3 ? {1'b1, 14'h1234} : 15'h0000, k == 0, CN[k]);
            chk({15'h0000, fstat[EI[k]]}, 16'h0001);
            xf(15'h0000);
            chk(rsp, ans(14'h0000, 1'b1));
            xf(15'h0000);
            chk(rsp, ans(14'h0000, 1'b1));
            xf(15'h7380);
            xf(15'h0000);
            chk(rsp, 16'h0000);
            chk({13'h0000, fstat[2:0]}, 16'h0000);
        end
        for (int r = 0; r < 3; r++) begin
            wr(ADDR_AGC, 14'h0011);
            @(posedge clk) {saw_rst, saw_osc, saw_start} = 3'h0;
            @(negedge clk) sleeping = r[0];
            wr(r == 2 ? ADDR_MASTER_RESET : ADDR_SOFT_RESET, {13'h0000, r[0]});
            wt(saw_rst);
            wt(saw_start);
            chk({4'h0, cfg}, {4'h0, TRIM});
            chk({15'h0000, saw_osc}, {15'h0000, r[0]});
            xf(15'h0000);
            chk(rsp, 16'h0000);
            fin();
        end
        conclude();
    end
endmodule : tb_escf_top
